// File: verilog/ppc_cfg.svh
// constants of the positioning command block: addresses, bits, timing
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// =====================================================================
// register addresses
`define PPC_CMD_WORD_ADDR 16'h6040
`define PPC_STATE_WORD_ADDR 16'h6041

// =====================================================================
// command word bits
`define PPC_CW_START 4
`define PPC_CW_IMMED 5
`define PPC_CW_REL 6
`define PPC_CW_HALT 8
`define PPC_CW_BLEND 9
`define PPC_CMD_RESET 16'h0000

// =====================================================================
// state word bits
`define PPC_SW_REACHED 10
`define PPC_SW_LIMIT 11
`define PPC_SW_ACK 12
`define PPC_SW_FERR 13

// =====================================================================
// mode and option code fields
`define PPC_MODE_PP 8'h01
`define PPC_OPT_REF_LO 0
`define PPC_OPT_CLR_LO 4
`define PPC_CLR_ON_ACCEPT 2'h1
`define PPC_CLR_ON_REACHED 2'h2

// =====================================================================
// timing: processing cycle
`define PPC_CLK_MHZ 10
`define PPC_CYCLE_US 1000
`define PPC_TICK_CYCLES (`PPC_CYCLE_US * `PPC_CLK_MHZ)

`endif

// File: verilog/ppc_pkg.sv
// types of the positioning command block
`default_nettype none
package ppc_pkg;

	// =================================================================
	// command sequencer states
	typedef enum logic [1:0] {
		PPC_IDLE = 2'b00,
		PPC_MOVING = 2'b01,
		PPC_QUEUED = 2'b10
	} ppc_state_t;

	// =================================================================
	// reference for relative targets
	typedef enum logic [1:0] {
		PPC_REF_PREV = 2'b00,
		PPC_REF_DEMAND = 2'b01,
		PPC_REF_ACTUAL = 2'b10,
		PPC_REF_RSVD = 2'b11
	} ppc_ref_t;

endpackage

`default_nettype wire

// File: verilog/ppc_tick.sv
// processing cycle strobe generator
`timescale 1ns/1ps
`default_nettype none

module ppc_tick #(
	parameter int TICK_CYCLES = 10000
) (
	input wire logic clock,
	input wire logic rst,
	output logic tick
);
	logic [15:0] count;
	localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);

	// =================================================================
	// divider
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= (count == LAST);
			count <= (count == LAST) ? 16'h0000 : count + 16'h0001;
		end
	end
endmodule

`default_nettype wire

// File: verilog/ppc_window_timer.sv
// counts processing cycles while a condition holds
`timescale 1ns/1ps
`default_nettype none

module ppc_window_timer (
	input wire logic clock,
	input wire logic rst,
	input wire logic tick,
	input wire logic cond,
	input wire logic [15:0] limit,
	output logic expired
);
	logic [15:0] count;
	wire at_limit = (count >= limit);

	// =================================================================
	// saturating cycle counter, restarts when condition drops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
			expired <= 1'b0;
		end else if (!cond) begin
			count <= 16'h0000;
			expired <= 1'b0;
		end else if (tick) begin
			expired <= at_limit;
			if (!at_limit) begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule

`default_nettype wire

// File: verilog/ppc_command.sv
// point-to-point positioning command handshake
`include "ppc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ppc_command import ppc_pkg::*; #(
	parameter int TICK_CYCLES = `PPC_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_word,
	output logic [15:0] state_word,
	input wire logic [7:0] operating_mode_select,
	input wire logic [7:0] pos_option_code,
	input wire logic signed [31:0] target_pos,
	input wire logic signed [31:0] pos_limit_min,
	input wire logic signed [31:0] pos_limit_max,
	input wire logic signed [31:0] demand_pos,
	input wire logic signed [31:0] actual_pos,
	input wire logic [31:0] pos_window,
	input wire logic [15:0] pos_window_time,
	input wire logic closed_loop,
	input wire logic [31:0] ferr_window,
	input wire logic [15:0] ferr_timeout,
	input wire logic target_reachable,
	input wire logic ramp_speed_met,
	input wire logic move_busy,
	output logic move_start,
	output logic signed [31:0] move_target,
	output logic move_blend,
	output logic halt_active,
	output logic halt_resume
);
	ppc_state_t state;
	ppc_state_t next_state;
	logic tick;
	logic [15:0] cw_prev;
	logic [7:0] mode_prev;
	logic ack;
	logic reached;
	logic limit_hit;
	logic ferr;
	logic signed [31:0] last_target;
	logic signed [31:0] pending_target;
	logic pending_blend;

	// =================================================================
	// processing cycle
	ppc_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.rst(rst),
		.tick(tick)
	);

	// =================================================================
	// mode and edge decode
	// mode gate
	wire enabled = (operating_mode_select == `PPC_MODE_PP);
	// mode entry counts as an edge
	wire entered = enabled && (mode_prev != `PPC_MODE_PP);
	wire start_edge = cmd_word[`PPC_CW_START] && (!cw_prev[`PPC_CW_START] || entered);
	// evaluation on the cycle strobe only
	wire trig = tick && enabled && start_edge;
	wire immed = cmd_word[`PPC_CW_IMMED];

	// =================================================================
	// target computation
	wire [1:0] ref_sel = pos_option_code[`PPC_OPT_REF_LO +: 2];
	wire [1:0] clr_sel = pos_option_code[`PPC_OPT_CLR_LO +: 2];
	logic signed [31:0] rel_base;
	always_comb begin
		case (ppc_ref_t'(ref_sel))
			PPC_REF_PREV: rel_base = last_target;
			PPC_REF_DEMAND: rel_base = demand_pos;
			PPC_REF_ACTUAL: rel_base = actual_pos;
			default: rel_base = last_target;
		endcase
	end
	wire signed [31:0] new_abs = cmd_word[`PPC_CW_REL] ? rel_base + target_pos : target_pos;
	wire in_limits = (new_abs >= pos_limit_min) && (new_abs <= pos_limit_max);

	// =================================================================
	// acceptance decode
	// reachability and pending check
	wire valid = target_reachable && in_limits && (immed || state != PPC_QUEUED);
	wire take = trig && !ack && valid;
	wire go_now = take && (immed || state == PPC_IDLE);
	wire queue = take && !immed && state == PPC_MOVING;
	wire run_pending = tick && enabled && state == PPC_QUEUED && !move_busy && !go_now;
	wire done = tick && state == PPC_MOVING && !move_busy && !take;
	wire want_blend = cmd_word[`PPC_CW_BLEND] && !immed && ramp_speed_met;

	// =================================================================
	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			PPC_IDLE: next_state = go_now ? PPC_MOVING : PPC_IDLE;
			PPC_MOVING: next_state = queue ? PPC_QUEUED : (done ? PPC_IDLE : PPC_MOVING);
			PPC_QUEUED: next_state = (go_now || run_pending) ? PPC_MOVING : PPC_QUEUED;
			default: next_state = PPC_IDLE;
		endcase
		if (!enabled) begin
			next_state = PPC_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= PPC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// =================================================================
	// sampled previous values
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cw_prev <= `PPC_CMD_RESET;
			mode_prev <= 8'h00;
		end else if (tick) begin
			cw_prev <= cmd_word;
			mode_prev <= operating_mode_select;
		end
	end

	// =================================================================
	// move outputs
	// start the accepted target
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			move_start <= 1'b0;
			move_target <= 32'h0000_0000;
			move_blend <= 1'b0;
			last_target <= 32'h0000_0000;
			pending_target <= 32'h0000_0000;
			pending_blend <= 1'b0;
		end else begin
			move_start <= go_now || run_pending;
			if (take) begin
				last_target <= new_abs;
			end
			if (go_now) begin
				move_target <= new_abs;
				move_blend <= 1'b0;
			end else if (run_pending) begin
				move_target <= pending_target;
				move_blend <= 1'b0;
			end else if (queue) begin
				pending_target <= new_abs;
				pending_blend <= want_blend;
				move_blend <= want_blend;
			end else if (state == PPC_QUEUED && !ramp_speed_met) begin
				move_blend <= 1'b0;
			end
		end
	end

	// =================================================================
	// acknowledge
	// drop with the strobe once start is low and the buffer is free
	wire ack_clear = !enabled || (tick && !cmd_word[`PPC_CW_START] && next_state != PPC_QUEUED);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
		end else if (take) begin
			ack <= 1'b1;
		end else if (ack_clear) begin
			ack <= 1'b0;
		end
	end

	// =================================================================
	// status flags
	wire signed [31:0] pos_err = actual_pos - move_target;
	wire signed [31:0] fol_err = demand_pos - actual_pos;
	wire signed [31:0] pos_err_mag = pos_err[31] ? -pos_err : pos_err;
	wire signed [31:0] fol_err_mag = fol_err[31] ? -fol_err : fol_err;
	wire in_window = $unsigned(pos_err_mag) <= pos_window;
	wire fol_over = $unsigned(fol_err_mag) > ferr_window;
	wire settle_cond = enabled && state == PPC_IDLE && in_window;
	wire ferr_cond = enabled && closed_loop && fol_over;

	ppc_window_timer u_settle (
		.clock(clock),
		.rst(rst),
		.tick(tick),
		.cond(settle_cond),
		.limit(pos_window_time),
		.expired(reached)
	);

	ppc_window_timer u_ferr (
		.clock(clock),
		.rst(rst),
		.tick(tick),
		.cond(ferr_cond),
		.limit(ferr_timeout),
		.expired(ferr)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			limit_hit <= 1'b0;
		end else if (!enabled) begin
			limit_hit <= 1'b0;
		end else if (tick) begin
			limit_hit <= (demand_pos > pos_limit_max) || (demand_pos < pos_limit_min);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_word <= 16'h0000;
		end else begin
			state_word <= 16'h0000;
			state_word[`PPC_SW_REACHED] <= reached;
			state_word[`PPC_SW_LIMIT] <= limit_hit;
			state_word[`PPC_SW_ACK] <= ack;
			state_word[`PPC_SW_FERR] <= ferr;
		end
	end

	// =================================================================
	// command word register
	wire cmd_hit = cmd_wr && (cmd_addr == `PPC_CMD_WORD_ADDR);
	logic reached_prev;
	wire self_clear = (take && clr_sel == `PPC_CLR_ON_ACCEPT) ||
		(reached && !reached_prev && clr_sel == `PPC_CLR_ON_REACHED);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_word <= `PPC_CMD_RESET;
			reached_prev <= 1'b0;
		end else begin
			reached_prev <= reached;
			if (cmd_hit) begin
				cmd_word <= cmd_wdata;
			end else if (self_clear) begin
				cmd_word[`PPC_CW_START] <= 1'b0;
			end
		end
	end

	// =================================================================
	// halt
	// halt level and ramp restart on release
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			halt_active <= 1'b0;
			halt_resume <= 1'b0;
		end else begin
			halt_resume <= tick && enabled && !cmd_word[`PPC_CW_HALT] && cw_prev[`PPC_CW_HALT];
			if (!enabled) begin
				halt_active <= 1'b0;
			end else if (tick) begin
				halt_active <= cmd_word[`PPC_CW_HALT];
			end
		end
	end

	// =================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_take;
		trig && !ack && valid && !immed && state == PPC_MOVING;
	endsequence
	sequence s_drain;
		tick && enabled && state == PPC_QUEUED && !move_busy;
	endsequence

	a_disabled_quiet: assert property (!enabled |=> !move_start)
		else $error("move started outside positioning mode");
	a_ack_blocks: assert property (tick && ack && state != PPC_QUEUED |=> !move_start)
		else $error("command taken while acknowledge set");
	a_immed_start: assert property (take && immed |=> move_start && move_target == $past(new_abs))
		else $error("immediate command not started");
	a_queue_drain: assert property (s_take ##[1:300] s_drain |=> move_start)
		else $error("queued target not started after completion");
	a_ack_sets: assert property (take |=> ##1 state_word[`PPC_SW_ACK])
		else $error("acknowledge missing after take");
	a_ack_held: assert property (state == PPC_QUEUED && ack && enabled
		&& !(tick && !move_busy) |=> ack)
		else $error("acknowledge dropped while buffer full");
	a_limit_flag: assert property (tick && enabled && demand_pos > pos_limit_max |=> limit_hit)
		else $error("limit flag not set");
	a_halt_resume: assert property (halt_resume |-> $past(tick) && !halt_active == $past(!cmd_word[`PPC_CW_HALT]))
		else $error("halt resume without release");
	a_self_clear: assert property (take && !cmd_hit && clr_sel == `PPC_CLR_ON_ACCEPT |=> !cmd_word[`PPC_CW_START])
		else $error("start bit not cleared");
	a_ferr_cond: assert property (ferr |-> $past(closed_loop) && $past(enabled))
		else $error("following error without closed loop");
endmodule

`default_nettype wire

// File: testbench/ppc_master.sv
// fieldbus master model: mode select, target and command word writes
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"

module ppc_master (
	input wire logic clock,
	output logic cmd_wr,
	output logic [15:0] cmd_addr,
	output logic [15:0] cmd_wdata,
	output logic [7:0] operating_mode_select,
	output logic signed [31:0] target_pos
);
	initial begin
		cmd_wr = 1'b0;
		cmd_addr = 16'h0000;
		cmd_wdata = 16'h0000;
		operating_mode_select = 8'h00;
		target_pos = 32'h0000_0000;
	end

	task put_mode(input logic [7:0] m);
		@(posedge clock);
		operating_mode_select <= m;
	endtask

	task put_target(input logic signed [31:0] t);
		@(posedge clock);
		target_pos <= t;
	endtask

	// released bus shows inverse of last value
	task write_word(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		cmd_wr <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clock);
		cmd_wr <= 1'b0;
		cmd_addr <= ~a;
		cmd_wdata <= ~d;
	endtask

	// command word written as given; the caller sets and clears the start bit
	task write_cmd(input logic [15:0] d);
		write_word(`PPC_CMD_WORD_ADDR, d);
	endtask
endmodule

`default_nettype wire

// File: testbench/ppc_command_bench.sv
// self-checking bench of the positioning command block
`timescale 1ns/1ps
`default_nettype none

module ppc_command_bench;
	localparam int TICK = 8;
	logic clock, rst, cmd_wr, closed_loop, target_reachable, ramp_speed_met, move_busy;
	logic move_start, move_blend, halt_active, halt_resume;
	logic [15:0] cmd_addr, cmd_wdata, cmd_word, state_word, pos_window_time, ferr_timeout;
	logic [7:0] operating_mode_select, pos_option_code;
	logic signed [31:0] target_pos, pos_limit_min, pos_limit_max, demand_pos, actual_pos;
	logic signed [31:0] move_target, last_tgt;
	logic [31:0] pos_window, ferr_window;
	int busy_left, busy_len, starts, resumes, errors, checks, s, r;

	ppc_master master (.clock(clock), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .operating_mode_select(operating_mode_select),
		.target_pos(target_pos));

	ppc_command #(.TICK_CYCLES(TICK)) dut (.clock(clock), .rst(rst), .cmd_wr(cmd_wr),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_word(cmd_word),
		.state_word(state_word), .operating_mode_select(operating_mode_select),
		.pos_option_code(pos_option_code), .target_pos(target_pos),
		.pos_limit_min(pos_limit_min), .pos_limit_max(pos_limit_max),
		.demand_pos(demand_pos), .actual_pos(actual_pos), .pos_window(pos_window),
		.pos_window_time(pos_window_time), .closed_loop(closed_loop),
		.ferr_window(ferr_window), .ferr_timeout(ferr_timeout),
		.target_reachable(target_reachable), .ramp_speed_met(ramp_speed_met),
		.move_busy(move_busy), .move_start(move_start), .move_target(move_target),
		.move_blend(move_blend), .halt_active(halt_active), .halt_resume(halt_resume));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// =================================================================
	// profile generator stand-in
	assign move_busy = busy_left != 0;
	always @(posedge clock) begin
		if (move_start) begin
			starts <= starts + 1;
			last_tgt <= move_target;
			busy_left <= busy_len;
		end else if (busy_left > 0) begin
			busy_left <= busy_left - 1;
		end
		if (halt_resume) begin
			resumes <= resumes + 1;
		end
	end

	// =================================================================
	// helpers
	task report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task hang(input string m);
		errors++;
		$display("BAD t=%0t %s", $time, m);
		report_and_stop();
	endtask

	task chk_bit(input logic got, input logic exp, input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t %s got %b", $time, m, got);
		end
	endtask

	task chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task ticks(input int n);
		repeat (n * TICK) @(negedge clock);
	endtask

	task expect_start(input int s0, input logic [31:0] t, input int lim);
		int i;
		for (i = 0; i < lim && starts == s0; i++) @(negedge clock);
		if (starts == s0) hang("no move start");
		chk_val(last_tgt, t, "move target");
	endtask

	task idle();
		int i;
		for (i = 0; i < 400 && move_busy; i++) @(negedge clock);
		if (move_busy) hang("busy stuck");
	endtask

	// =================================================================
	// scenarios
	task t_regs();
		master.write_word(16'h6041, 16'hffff);
		@(negedge clock);
		chk_val(32'(cmd_word), 32'h0000_0000, "write elsewhere");
		master.write_cmd(16'h0020);
		@(negedge clock);
		chk_val(32'(cmd_word), 32'h0000_0020, "readback");
		master.write_cmd(16'h0000);
		$display("done regs");
	endtask

	task t_mode();
		busy_len = 24;
		s = starts;
		master.put_target(32'h0000_1000);
		master.put_mode(8'h03);
		master.write_cmd(16'h0010);
		ticks(3);
		chk_bit(starts == s, 1'b1, "start outside mode");
		master.put_mode(8'h01);
		expect_start(s, 32'h0000_1000, 40);
		ticks(1);
		chk_bit(state_word[12], 1'b1, "ack set");
		chk_bit(state_word[10], 1'b0, "reached while moving");
		master.write_cmd(16'h0000);
		ticks(3);
		chk_bit(state_word[12], 1'b0, "ack clear");
		ticks(6);
		chk_bit(state_word[10], 1'b1, "reached");
		@(posedge clock);
		actual_pos <= 32'h0000_1020;
		ticks(1);
		chk_bit(state_word[10], 1'b0, "left window");
		@(posedge clock);
		pos_window <= 32'h0000_0040;
		pos_window_time <= 16'h0001;
		ticks(3);
		chk_bit(state_word[10], 1'b1, "wider window");
		@(posedge clock);
		actual_pos <= 32'h0000_1000;
		$display("done mode");
	endtask

	task t_queue();
		idle();
		busy_len = 160;
		s = starts;
		master.put_target(32'h0000_2000);
		master.write_cmd(16'h0010);
		expect_start(s, 32'h0000_2000, 40);
		master.write_cmd(16'h0000);
		ticks(2);
		chk_bit(state_word[12], 1'b0, "room signalled");
		master.put_target(32'h0000_3000);
		master.write_cmd(16'h0010);
		ticks(3);
		chk_bit(starts == s + 1, 1'b1, "queued run early");
		chk_bit(state_word[12], 1'b1, "queued ack");
		master.write_cmd(16'h0000);
		ticks(2);
		chk_bit(state_word[12], 1'b1, "ack while full");
		master.put_target(32'h0000_4000);
		master.write_cmd(16'h0010);
		expect_start(s + 1, 32'h0000_3000, 300);
		master.write_cmd(16'h0000);
		ticks(3);
		chk_bit(starts == s + 2 && state_word[12] == 1'b0, 1'b1, "discard");
		$display("done queue");
	endtask

	task t_immediate();
		idle();
		s = starts;
		master.put_target(32'h0000_5000);
		master.write_cmd(16'h0030);
		expect_start(s, 32'h0000_5000, 40);
		master.write_cmd(16'h0020);
		ticks(3);
		master.put_target(32'h0000_6000);
		master.write_cmd(16'h0030);
		expect_start(s + 1, 32'h0000_6000, 24);
		master.write_cmd(16'h0020);
		ticks(3);
		master.put_target(32'h0000_0100);
		master.write_cmd(16'h0070);
		expect_start(s + 2, 32'h0000_6100, 24);
		master.write_cmd(16'h0020);
		ticks(3);
		@(posedge clock);
		pos_option_code <= 8'h01;
		master.put_target(32'h0000_0100);
		master.write_cmd(16'h0070);
		expect_start(s + 3, 32'h0000_1100, 24);
		master.write_cmd(16'h0020);
		ticks(3);
		@(posedge clock);
		pos_option_code <= 8'h02;
		actual_pos <= 32'h0000_2000;
		master.write_cmd(16'h0070);
		expect_start(s + 4, 32'h0000_2100, 24);
		master.write_cmd(16'h0020);
		ticks(3);
		@(posedge clock);
		pos_option_code <= 8'h00;
		actual_pos <= 32'h0000_1000;
		$display("done immediate");
	endtask

	task t_limit();
		idle();
		s = starts;
		master.put_target(32'h0020_0000);
		master.write_cmd(16'h0010);
		ticks(3);
		chk_bit(starts == s && state_word[12] == 1'b0, 1'b1, "outside limits");
		master.write_cmd(16'h0000);
		@(posedge clock);
		target_reachable <= 1'b0;
		master.put_target(32'h0000_1000);
		master.write_cmd(16'h0010);
		ticks(3);
		chk_bit(starts == s && state_word[12] == 1'b0, 1'b1, "unreachable");
		master.write_cmd(16'h0000);
		@(posedge clock);
		target_reachable <= 1'b1;
		demand_pos <= 32'h0020_0000;
		ticks(2);
		chk_bit(state_word[11], 1'b1, "limit set");
		@(posedge clock);
		pos_limit_max <= 32'h0030_0000;
		ticks(2);
		chk_bit(state_word[11], 1'b0, "limit raised");
		@(posedge clock);
		pos_limit_max <= 32'h0010_0000;
		pos_limit_min <= 32'h0000_2000;
		demand_pos <= 32'h0000_1000;
		ticks(2);
		chk_bit(state_word[11], 1'b1, "below limit");
		@(posedge clock);
		pos_limit_min <= -32'sh0010_0000;
		ticks(2);
		chk_bit(state_word[11], 1'b0, "limit clear");
		$display("done limit");
	endtask

	task t_ferr_halt();
		@(posedge clock);
		demand_pos <= 32'h0000_1800;
		ferr_timeout <= 16'h0003;
		ticks(6);
		chk_bit(state_word[13], 1'b0, "ferr open loop");
		@(posedge clock);
		closed_loop <= 1'b1;
		ferr_window <= 32'h0000_1000;
		ticks(6);
		chk_bit(state_word[13], 1'b0, "ferr inside window");
		@(posedge clock);
		ferr_window <= 32'h0000_0100;
		ticks(6);
		chk_bit(state_word[13], 1'b1, "ferr set");
		@(posedge clock);
		closed_loop <= 1'b0;
		demand_pos <= 32'h0000_1000;
		r = resumes;
		master.write_cmd(16'h0100);
		ticks(2);
		chk_bit(halt_active == 1'b1 && resumes == r, 1'b1, "halt");
		master.write_cmd(16'h0000);
		ticks(2);
		chk_bit(halt_active == 1'b0 && resumes == r + 1, 1'b1, "resume");
		$display("done ferr halt");
	endtask

	task t_blend();
		idle();
		@(posedge clock);
		ramp_speed_met <= 1'b1;
		s = starts;
		master.put_target(32'h0000_7000);
		master.write_cmd(16'h0010);
		expect_start(s, 32'h0000_7000, 40);
		master.write_cmd(16'h0000);
		ticks(2);
		master.put_target(32'h0000_8000);
		master.write_cmd(16'h0210);
		ticks(3);
		chk_bit(move_blend, 1'b1, "blend");
		@(posedge clock);
		ramp_speed_met <= 1'b0;
		ticks(2);
		chk_bit(move_blend, 1'b0, "blend ignored");
		expect_start(s + 1, 32'h0000_8000, 300);
		master.write_cmd(16'h0000);
		ticks(3);
		$display("done blend");
	endtask

	task t_selfclr();
		idle();
		busy_len = 24;
		@(posedge clock);
		pos_option_code <= 8'h10;
		s = starts;
		master.put_target(32'h0000_9000);
		master.write_cmd(16'h0010);
		expect_start(s, 32'h0000_9000, 40);
		ticks(1);
		chk_bit(cmd_word[4], 1'b0, "start self clear");
		@(posedge clock);
		pos_option_code <= 8'h00;
		$display("done selfclr");
	endtask

	task t_reset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk_val(32'(cmd_word), 32'h0000_0000, "reset cmd word");
		chk_val(32'(state_word), 32'h0000_0000, "reset state word");
		chk_val(move_target, 32'h0000_0000, "reset target");
		$display("done reset");
	endtask

	// =================================================================
	// main sequence
	initial begin
		rst = 1'b1;
		{closed_loop, ramp_speed_met} = 2'b00;
		target_reachable = 1'b1;
		pos_option_code = 8'h00;
		pos_limit_min = -32'sh0010_0000;
		pos_limit_max = 32'h0010_0000;
		demand_pos = 32'h0000_1000;
		actual_pos = 32'h0000_1000;
		pos_window = 32'h0000_0010;
		pos_window_time = 16'h0002;
		ferr_window = 32'h0000_0100;
		ferr_timeout = 16'h0002;
		{busy_len, errors, checks} = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_mode();
		t_queue();
		t_immediate();
		t_limit();
		t_ferr_halt();
		t_blend();
		t_selfclr();
		t_reset();
		report_and_stop();
	end
endmodule

`default_nettype wire
